// file: shared/asr_regs.vh
// Register offsets, field positions, reset values and timing counts for
// the asynchronous serial receiver. Definitions only; included by bare name.
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// Register byte offsets on APB
`define ASR_CTRL_OFF        8'h00
`define ASR_DIV_OFF         8'h04
`define ASR_STATUS_OFF      8'h08
`define ASR_DATA_OFF        8'h0c
`define ASR_CMD_OFF         8'h10

// Control word fields
`define ASR_CTRL_WLS_LO     0
`define ASR_CTRL_WLS_HI     1
`define ASR_CTRL_PI         2
`define ASR_CTRL_EPE        3
`define ASR_CTRL_SBS        4
`define ASR_CTRL_RESET      5'h00

// Status fields
`define ASR_ST_AVAIL        0
`define ASR_ST_PERR         1
`define ASR_ST_FERR         2
`define ASR_ST_OERR         3
`define ASR_ST_BUSY         4

// Command fields (write-only strobes)
`define ASR_CMD_CLR_AVAIL   0
`define ASR_CMD_MRESET      1

// Timing: 16x sample rate, pclk cycles per 16x period
`define ASR_OVERSAMPLE      16
`define ASR_PCLK_HZ         25000000
`define ASR_BAUD_DEFAULT    9600
`define ASR_DIV_RESET       (`ASR_PCLK_HZ / (`ASR_OVERSAMPLE * `ASR_BAUD_DEFAULT))
`define ASR_CENTRE_TICK     4'd7
`define ASR_PRELOAD_TICK    4'd6

`endif

// file: logic/asr_tick_div.v
// Divider that makes the 16x sample enable and its mid-period enable.
// Assumes divisor is at least 2; a smaller value is treated as 2.
`timescale 1ns/1ns
`default_nettype none

module asr_tick_div #(
  parameter W = 16
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         restart,
  input  wire [W-1:0] divisor,
  output reg          tick,
  output reg          half
);

  reg  [W-1:0] cnt_reg;
  wire [W-1:0] div_eff;
  wire [W-1:0] half_pt;

  // Clamp divisor and find the half-period point
  assign div_eff = (divisor < 2) ? {{(W-2){1'b0}}, 2'b10} : divisor;
  assign half_pt = div_eff >> 1;

  // Free-running count with one-cycle enables
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
      half    <= 1'b0;
    end
    else if (restart)
    begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
      half    <= 1'b0;
    end
    else
    begin
      tick <= (cnt_reg == div_eff - 1'b1);
      half <= (cnt_reg == half_pt - 1'b1);
      if (cnt_reg >= div_eff - 1'b1)
        cnt_reg <= {W{1'b0}};
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // asr_tick_div

`default_nettype wire

// file: logic/asr_receiver.v
// Receive half of an asynchronous start-stop serial port with APB registers.
// Assumes line_in_bit and the strobe pins are synchronous to pclk.
//
// Notes on behaviour
// - Idle line high: watch for falling edge
// - Verify start low at centre, else noise
// - Sample every later bit at its centre
// - Length, parity follow control word; stop select unused
// - Assembly register shortened to character length
// - Parity mismatch flag held until next transfer
// - Only first stop checked; low sets framing
// - Transfer to holding sets character available
// - Low clear strobe drops character available
// - Uncleared flag at transfer sets overrun
// - Master reset forces idle, then search
// - Data valid half period before flags
// - Flags updated at first stop centre
// - Character held until next is assembled
// - Frame: low start, parity, high stops
// - Start centre at count seven and half
// - Resume search at first stop centre
// - After break, wait for high level
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.vh"

module asr_receiver #(
  parameter DIV_W       = 16,
  parameter DIV_DEFAULT = `ASR_DIV_RESET
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        line_in_bit,
  input  wire        master_reset,
  input  wire        char_available_clear_n,
  output wire [7:0]  rx_data,
  output wire        char_available,
  output wire        parity_error,
  output wire        framing_error,
  output wire        overrun_error
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam ST_IDLE   = 3'd0;
  localparam ST_START  = 3'd1;
  localparam ST_DATA   = 3'd2;
  localparam ST_PARITY = 3'd3;
  localparam ST_STOP   = 3'd4;
  localparam ST_WAITHI = 3'd5;

  reg  [4:0]       ctrl_reg;
  reg  [DIV_W-1:0] div_reg;
  reg  [2:0]       state_reg;
  reg  [3:0]       tcnt_reg;
  reg  [2:0]       bit_reg;
  reg  [7:0]       shift_reg;
  reg  [7:0]       hold_reg;
  reg              par_acc_reg;
  reg              perr_pend_reg;
  reg              line_prev_reg;
  reg              avail_reg;
  reg              perr_reg;
  reg              ferr_reg;
  reg              oerr_reg;

  wire             tick;
  wire             half;
  wire             apb_wr;
  wire             apb_rd;
  wire             addr_ok;
  wire             cmd_clr;
  wire             cmd_mrst;
  wire             mrst;
  wire             clr_avail;
  wire [2:0]       last_bit;
  wire             par_on;
  wire             centre;
  wire             flag_upd;
  wire             stop_ok;

  ////////////////////////////////////////////////////////////////////////
  // APB slave decode

  // Zero-wait slave; unknown offsets answer with an error
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `ASR_CTRL_OFF) || (paddr == `ASR_DIV_OFF) ||
                   (paddr == `ASR_STATUS_OFF) || (paddr == `ASR_DATA_OFF) ||
                   (paddr == `ASR_CMD_OFF);
  assign pslverr = psel & penable & ~addr_ok;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;

  // Command strobes from a write to the command word
  assign cmd_clr  = apb_wr & (paddr == `ASR_CMD_OFF) & pwdata[`ASR_CMD_CLR_AVAIL];
  assign cmd_mrst = apb_wr & (paddr == `ASR_CMD_OFF) & pwdata[`ASR_CMD_MRESET];
  assign mrst     = master_reset | cmd_mrst;
  assign clr_avail = ~char_available_clear_n | cmd_clr;

  // Writable configuration
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `ASR_CTRL_RESET;
      div_reg  <= DIV_DEFAULT[DIV_W-1:0];
    end
    else if (apb_wr)
    begin
      if (paddr == `ASR_CTRL_OFF)
        ctrl_reg <= pwdata[4:0];
      if (paddr == `ASR_DIV_OFF)
        div_reg <= pwdata[DIV_W-1:0];
    end
  end

  // Read mux; reserved bits read zero
  always @*
  begin
    prdata = 32'h0000_0000;
    if (apb_rd)
    begin
      case (paddr)
        `ASR_CTRL_OFF:   prdata[4:0] = ctrl_reg;
        `ASR_DIV_OFF:    prdata[DIV_W-1:0] = div_reg;
        `ASR_STATUS_OFF:
        begin
          prdata[`ASR_ST_AVAIL] = avail_reg;
          prdata[`ASR_ST_PERR]  = perr_reg;
          prdata[`ASR_ST_FERR]  = ferr_reg;
          prdata[`ASR_ST_OERR]  = oerr_reg;
          prdata[`ASR_ST_BUSY]  = (state_reg != ST_IDLE);
        end
        `ASR_DATA_OFF:   prdata[7:0] = hold_reg;
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample clock

  // 16x enable and mid-period enable from pclk
  asr_tick_div #(
    .W (DIV_W)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (mrst),
    .divisor (div_reg),
    .tick    (tick),
    .half    (half)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame decode helpers

  // Last data bit index from word length select
  assign last_bit = {1'b1, ctrl_reg[`ASR_CTRL_WLS_HI], ctrl_reg[`ASR_CTRL_WLS_LO]};
  assign par_on   = ~ctrl_reg[`ASR_CTRL_PI];

  // Bit centre sits half a 16x period after count seven
  assign centre   = half & (tcnt_reg == `ASR_CENTRE_TICK);
  assign stop_ok  = line_in_bit;
  assign flag_upd = centre & (state_reg == ST_STOP);

  ////////////////////////////////////////////////////////////////////////
  // Receive sequencer

  // Line watch, start check, bit sampling and assembly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= ST_IDLE;
      tcnt_reg      <= 4'h0;
      bit_reg       <= 3'd0;
      shift_reg     <= 8'h00;
      hold_reg      <= 8'h00;
      par_acc_reg   <= 1'b0;
      perr_pend_reg <= 1'b0;
      line_prev_reg <= 1'b1;
    end
    else if (mrst)
    begin
      state_reg     <= ST_IDLE;
      tcnt_reg      <= 4'h0;
      bit_reg       <= 3'd0;
      par_acc_reg   <= 1'b0;
      perr_pend_reg <= 1'b0;
      line_prev_reg <= 1'b1;
    end
    else
    begin
      if (tick)
        line_prev_reg <= line_in_bit;
      if (tick && state_reg != ST_IDLE)
        tcnt_reg <= tcnt_reg + 4'h1;
      case (state_reg)
        ST_IDLE:
        begin
          // High-to-low seen at a 16x tick starts the count
          if (tick && line_prev_reg && !line_in_bit)
          begin
            state_reg <= ST_START;
            tcnt_reg  <= 4'h0;
          end
        end
        ST_START:
        begin
          if (centre)
          begin
            if (!line_in_bit)
            begin
              state_reg   <= ST_DATA;
              bit_reg     <= 3'd0;
              shift_reg   <= 8'h00;
              par_acc_reg <= 1'b0;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_DATA:
        begin
          if (centre)
          begin
            // Only the configured bits are collected
            shift_reg[bit_reg] <= line_in_bit;
            par_acc_reg        <= par_acc_reg ^ line_in_bit;
            bit_reg            <= bit_reg + 3'd1;
            if (bit_reg == last_bit)
              state_reg <= par_on ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY:
        begin
          if (centre)
          begin
            // Even: total ones even; odd: total ones odd
            perr_pend_reg <= ctrl_reg[`ASR_CTRL_EPE] ?
                             (par_acc_reg ^ line_in_bit) :
                             ~(par_acc_reg ^ line_in_bit);
            state_reg     <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          // Holding data moves half a period ahead of the flags
          if (tick && tcnt_reg == `ASR_PRELOAD_TICK)
            hold_reg <= shift_reg;
          if (centre)
          begin
            perr_pend_reg <= 1'b0;
            // Search resumes here; a low stop waits for a mark first
            state_reg <= stop_ok ? ST_IDLE : ST_WAITHI;
            if (!stop_ok)
              line_prev_reg <= 1'b0;
          end
        end
        ST_WAITHI:
        begin
          if (tick && line_in_bit)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  // Set at first stop centre; a set wins over a same-cycle clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      avail_reg <= 1'b0;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
      oerr_reg  <= 1'b0;
    end
    else if (mrst)
    begin
      avail_reg <= 1'b0;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
      oerr_reg  <= 1'b0;
    end
    else if (flag_upd)
    begin
      avail_reg <= 1'b1;
      perr_reg  <= par_on & perr_pend_reg;
      ferr_reg  <= ~stop_ok;
      oerr_reg  <= avail_reg & ~clr_avail;
    end
    else if (clr_avail)
      avail_reg <= 1'b0;
  end

  // Outputs straight from registers
  assign rx_data        = hold_reg;
  assign char_available = avail_reg;
  assign parity_error   = perr_reg;
  assign framing_error  = ferr_reg;
  assign overrun_error  = oerr_reg;

endmodule // asr_receiver

`default_nettype wire

// file: verification/asr_rx_monitor.sv
// Checker on the receiver ports: flag timing, clears, read path.
// Assumes a divisor of 2, so flags follow a data load by one pclk.
`timescale 1ns/1ns
`default_nettype none
module asr_rx_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        master_reset,
  input wire logic        char_available_clear_n,
  input wire logic [7:0]  rx_data,
  input wire logic        char_available,
  input wire logic        parity_error,
  input wire logic        framing_error,
  input wire logic        overrun_error
);
  logic [7:0] rx_q;
  logic [2:0] age;
  logic [1:0] wl_q;
  wire        chg = rx_data != rx_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////
  // Age of the last data load and programmed length
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_q <= 8'h00;
      age  <= 3'h7;
      wl_q <= 2'h0;
    end
    else
    begin
      rx_q <= rx_data;
      age  <= chg ? 3'h0 : age + {2'h0, age != 3'h7};
      if (psel && penable && pwrite && paddr == 8'h00)
        wl_q <= pwdata[1:0];
    end
  end
  //////////////////////////////////////////////////
  // Flag and data timing
  avail_clr_a: assert property (
    !char_available_clear_n && !chg |=> !char_available) else $error("avail not cleared");
  avail_set_a: assert property (
    chg |-> ##[0:4] char_available) else $error("avail not set");
  overrun_set_a: assert property (
    chg && char_available && char_available_clear_n |-> ##[0:4] overrun_error)
    else $error("overrun not set");
  mreset_idle_a: assert property (
    master_reset |=> !(char_available || parity_error || framing_error || overrun_error))
    else $error("flags kept in reset");
  data_first_a: assert property (
    $rose(char_available) |-> $stable(rx_data) && age != 3'h7) else $error("data late");
  flag_time_a: assert property (
    $changed({parity_error, framing_error, overrun_error})
    |-> age < 3'h3 || $past(master_reset) || $past(psel)) else $error("flag off time");
  upper_zero_a: assert property (
    chg |-> (rx_data >> (4'd5 + wl_q)) == 8'h00) else $error("upper bits set");
  data_read_a: assert property (
    psel && penable && !pwrite && paddr == 8'h0c |-> prdata == {24'h0, rx_data})
    else $error("data read wrong");
endmodule // asr_rx_monitor
`default_nettype wire

// file: verification/asr_tx_model.sv
// Far-end transmitter model driving the serial line, idle at mark.
// Assumes callers start on a rising pclk edge; BITP is pclk per bit.
`timescale 1ns/1ns
`default_nettype none
module asr_tx_model #(
  parameter int BITP = 32
) (
  input  wire logic pclk,
  output var  logic line
);
  //////////////////////////////////////////////////
  // Line rests at mark until the first frame
  initial line = 1'b1;
  // One symbol held for t cycles
  task automatic put(input logic b, input int t = BITP);
    line <= b;
    repeat (t) @(posedge pclk);
  endtask
  // Start, data LSB first, optional parity, two stop symbols
  task automatic send(input logic [7:0] d, input int n, input logic pen, ev, bad, stop);
    put(1'b0);
    for (int i = 0; i < n; i++)
      put(d[i]);
    if (pen)
      put(^d ^ ~ev ^ bad);
    put(stop);
    put(stop);
  endtask
endmodule // asr_tx_model
`default_nettype wire

// file: verification/tb_top.sv
// Testbench for the serial receiver: APB host, far-end model, checks.
// Assumes a divisor of 2, so one bit lasts 32 pclk cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, line_in_bit, e;
  logic        master_reset, char_available_clear_n, pready, pslverr;
  logic        char_available, parity_error, framing_error, overrun_error;
  logic [7:0]  paddr, rx_data;
  logic [31:0] pwdata, prdata, r;
  int          fails, check_count;
  //////////////////////////////////////////////////
  // Design, far end and clock
  asr_receiver #(.DIV_DEFAULT(2)) u_asr_receiver (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .line_in_bit            (line_in_bit),
    .master_reset           (master_reset),
    .char_available_clear_n (char_available_clear_n),
    .rx_data                (rx_data),
    .char_available         (char_available),
    .parity_error           (parity_error),
    .framing_error          (framing_error),
    .overrun_error          (overrun_error)
  );
  asr_tx_model #(.BITP(32)) u_asr_tx_model (.pclk, .line(line_in_bit));
  always #20 pclk = ~pclk;
  //////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string w, input logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic flags(input logic [3:0] x);
    check("flags", {overrun_error, framing_error, parity_error, char_available}, x);
  endtask
  task automatic clr;
    char_available_clear_n <= 1'b0;
    @(posedge pclk);
    char_available_clear_n <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic tx(input logic [7:0] d, input logic b = 1'b0, input logic s = 1'b1);
    u_asr_tx_model.send(d, 8, 1'b1, 1'b0, b, s);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////
  // Scenarios
  task automatic s_regs;
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", r, 32'h0);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", r, 32'h1f);
    apb(1'b0, 8'h04, 32'h0);
    check("divisor", r, 32'h2);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
  endtask
  task automatic s_fmt;
    logic [7:0] d;
    for (int c = 0; c < 32; c++)
    begin
      d = 8'(c * 37 + 1) & (8'hff >> (2'd3 - c[1:0]));
      apb(1'b1, 8'h00, 32'(c));
      u_asr_tx_model.send(d, 5 + c[1:0], !c[2], c[3], 1'b0, 1'b1);
      check("data", {24'h0, rx_data}, {24'h0, d});
      flags(4'h1);
      clr;
      flags(4'h0);
    end
  endtask
  task automatic s_par;
    apb(1'b1, 8'h00, 32'h3);
    tx(8'h3c, 1'b1);
    clr;
    flags(4'h2);
    tx(8'hc3);
    flags(4'h1);
    clr;
  endtask
  task automatic s_ovr;
    tx(8'h11);
    tx(8'h22);
    flags(4'h9);
    apb(1'b0, 8'h0c, 32'h0);
    check("read", r, 32'h22);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check("status", r, 32'h8);
    tx(8'h33);
    flags(4'h1);
    clr;
  endtask
  task automatic s_brk;
    tx(8'h00, 1'b0, 1'b0);
    flags(4'h5);
    clr;
    u_asr_tx_model.put(1'b0, 320);
    flags(4'h4);
    u_asr_tx_model.put(1'b1, 64);
    tx(8'h5a);
    check("data", {24'h0, rx_data}, 32'h5a);
    flags(4'h1);
    clr;
    u_asr_tx_model.put(1'b0, 6);
    u_asr_tx_model.put(1'b1, 640);
    flags(4'h0);
    tx(8'h66);
    check("data", {24'h0, rx_data}, 32'h66);
  endtask
  task automatic s_mrst;
    tx(8'h81, 1'b1);
    master_reset <= 1'b1;
    @(posedge pclk);
    master_reset <= 1'b0;
    @(posedge pclk);
    flags(4'h0);
    check("kept", {24'h0, rx_data}, 32'h81);
    tx(8'h18, 1'b1);
    apb(1'b1, 8'h10, 32'h2);
    flags(4'h0);
    tx(8'h42);
    flags(4'h1);
  endtask
  //////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    master_reset = 1'b0;
    char_available_clear_n = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs;
    s_fmt;
    s_par;
    s_ovr;
    s_brk;
    s_mrst;
    summarize;
  end
  initial
  begin
    #1600000;
    fails++;
    summarize;
  end
endmodule // tb_top
bind asr_receiver asr_rx_monitor u_asr_rx_monitor (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .master_reset, .char_available_clear_n, .rx_data,
  .char_available, .parity_error, .framing_error, .overrun_error);
`default_nettype wire
